/* File: hw/pit_pkg.sv */
package pit_pkg;

    // register word addresses on the data memory port
    localparam logic [3:0]  PIT_ADDR_PERIOD    = 4'h0;
    localparam logic [3:0]  PIT_ADDR_SCALE     = 4'h1;
    localparam logic [3:0]  PIT_ADDR_COUNT     = 4'h2;

    // field widths and positions
    localparam int          PIT_COUNT_W        = 16;
    localparam int          PIT_SCALE_W        = 8;
    localparam int          PIT_MODE_W         = 7;
    localparam int          PIT_ENABLE_BIT     = 5;

    // values after reset
    localparam logic [15:0] PIT_COUNT_RST      = 16'h0000;
    localparam logic [15:0] PIT_PERIOD_RST     = 16'h0000;
    localparam logic [7:0]  PIT_SCALE_RST      = 8'h00;
    localparam logic [15:0] PIT_RDATA_RST      = 16'h0000;

    // one register access from the core
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [3:0]  addr;
        logic [15:0] wdata;
    } pit_req_t;

endpackage

/* File: hw/pit_timer.sv */
`timescale 1ns/1ns
// Overview of operation
// - prescale holds cycles between decrements minus one
// - sixteen-bit down counter, prescaler stretches interval
// - steady interrupt every (period+1)*(prescale+1) cycles
// - first interrupt after (count+1)*(prescale+1)+1 cycles from enable
// - prescale and count writes act immediately
// - period writes wait for next reload
// - zero raises interrupt and reload from period on the same tick
// - first decrement only after one prescale interval
// - counting continues after reload without software
// - mode status bit five enables, clear holds
// - count, period sixteen bits; prescale eight bits
module pit_timer
    import pit_pkg::*;
(
    input  wire logic                  mclk_i,
    input  wire logic                  resetn_i,
    input  wire pit_req_t              req_i,
    input  wire logic [PIT_MODE_W-1:0] mode_status_word_i,
    output logic [PIT_COUNT_W-1:0]     rdata_o,
    output logic                       timer_irq_o
);

    // run phase: halted, or enabled since the previous edge
    typedef enum logic [1:0] {
        PIT_PH_HALT = 2'b01,
        PIT_PH_RUN  = 2'b10
    } pit_phase_t;

    // what the count does on this edge
    typedef enum logic [3:0] {
        PIT_CA_HOLD   = 4'b0001,
        PIT_CA_LOAD   = 4'b0010,
        PIT_CA_STEP   = 4'b0100,
        PIT_CA_RELOAD = 4'b1000
    } pit_count_act_t;

    // timer registers
    logic [PIT_COUNT_W-1:0] down_count;
    logic [PIT_COUNT_W-1:0] reload_period;
    logic [PIT_SCALE_W-1:0] prescale_value;
    logic [PIT_SCALE_W-1:0] scale_cnt;
    pit_phase_t             phase;

    // next values of the registers
    logic [PIT_COUNT_W-1:0] next_down_count;
    logic [PIT_COUNT_W-1:0] next_reload_period;
    logic [PIT_SCALE_W-1:0] next_prescale_value;
    logic [PIT_SCALE_W-1:0] next_scale_cnt;
    pit_phase_t             next_phase;
    logic                   next_timer_irq;
    logic [PIT_COUNT_W-1:0] next_rdata;
    pit_count_act_t         count_act;

    // decoded controls
    logic                   enabled;
    logic                   running;
    logic                   scale_due;
    logic                   tick;
    logic                   count_zero;
    logic                   wr_period;
    logic                   wr_scale;
    logic                   wr_count;
    logic                   rd_any;

    // address decode of a write
    function automatic logic hit(input pit_req_t r, input logic [3:0] a);
        hit = r.wr && (r.addr == a);
    endfunction

    // count has run out and waits for a reload
    function automatic logic at_zero(input logic [PIT_COUNT_W-1:0] c);
        at_zero = (c == '0);
    endfunction

    // word returned for a read address, unmapped reads as zero
    function automatic logic [PIT_COUNT_W-1:0] read_word(
        input logic [3:0]             a,
        input logic [PIT_COUNT_W-1:0] p,
        input logic [PIT_SCALE_W-1:0] s,
        input logic [PIT_COUNT_W-1:0] c
    );
        case (a)
            PIT_ADDR_PERIOD: begin
                read_word = p;
            end
            PIT_ADDR_SCALE: begin
                read_word = {8'h00, s};
            end
            PIT_ADDR_COUNT: begin
                read_word = c;
            end
            default: begin
                read_word = PIT_RDATA_RST;
            end
        endcase
    endfunction

    // write strobes per register
    assign wr_period = hit(req_i, PIT_ADDR_PERIOD);
    assign wr_scale  = hit(req_i, PIT_ADDR_SCALE);
    assign wr_count  = hit(req_i, PIT_ADDR_COUNT);
    assign rd_any    = req_i.rd;

    // timer enable from the mode status word
    assign enabled = mode_status_word_i[PIT_ENABLE_BIT];

    // counting only from the second enabled cycle on
    assign running = enabled && (phase == PIT_PH_RUN);

    // prescale interval has run its full length
    assign scale_due = scale_cnt >= prescale_value;

    // decrement strobe once the prescale interval has elapsed
    assign tick = running
                  && scale_due;

    // count has run out
    assign count_zero = at_zero(down_count);

    // next phase of the enable tracker
    always_comb begin
        case (phase)
            PIT_PH_HALT: begin
                if (enabled) begin
                    next_phase = PIT_PH_RUN;
                end else begin
                    next_phase = PIT_PH_HALT;
                end
            end
            PIT_PH_RUN: begin
                if (enabled) begin
                    next_phase = PIT_PH_RUN;
                end else begin
                    next_phase = PIT_PH_HALT;
                end
            end
            default: begin
                next_phase = PIT_PH_HALT;
            end
        endcase
    end

    // next prescale cycle count, restarted on enable and each tick
    always_comb begin
        case (phase)
            PIT_PH_HALT: begin
                next_scale_cnt = '0;
            end
            PIT_PH_RUN: begin
                if (!enabled || tick) begin
                    next_scale_cnt = '0;
                end else begin
                    next_scale_cnt = scale_cnt + 8'h01;
                end
            end
            default: begin
                next_scale_cnt = '0;
            end
        endcase
    end

    // next prescale register, written at once
    always_comb begin
        if (wr_scale) begin
            next_prescale_value = req_i.wdata[PIT_SCALE_W-1:0];
        end else begin
            next_prescale_value = prescale_value;
        end
    end

    // next period, kept apart from the running countdown
    always_comb begin
        if (wr_period) begin
            next_reload_period = req_i.wdata;
        end else begin
            next_reload_period = reload_period;
        end
    end

    // choose the count action: write, reload, step or hold
    always_comb begin
        if (wr_count) begin
            count_act = PIT_CA_LOAD;
        end else if (tick && count_zero) begin
            count_act = PIT_CA_RELOAD;
        end else if (tick) begin
            count_act = PIT_CA_STEP;
        end else begin
            count_act = PIT_CA_HOLD;
        end
    end

    // next count from the chosen action
    always_comb begin
        case (count_act)
            PIT_CA_LOAD: begin
                next_down_count = req_i.wdata;
            end
            PIT_CA_RELOAD: begin
                next_down_count = reload_period;
            end
            PIT_CA_STEP: begin
                next_down_count = down_count - 16'h0001;
            end
            PIT_CA_HOLD: begin
                next_down_count = down_count;
            end
            default: begin
                next_down_count = down_count;
            end
        endcase
    end

    // interrupt on the reload tick; a count write suppresses it
    always_comb begin
        case (count_act)
            PIT_CA_RELOAD: begin
                next_timer_irq = 1'b1;
            end
            default: begin
                next_timer_irq = 1'b0;
            end
        endcase
    end

    // next read data, held between reads
    always_comb begin
        case (rd_any)
            1'b1: begin
                next_rdata = read_word(req_i.addr, reload_period,
                                       prescale_value, down_count);
            end
            default: begin
                next_rdata = rdata_o;
            end
        endcase
    end

    // enable tracker
    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            phase <= PIT_PH_HALT;
        end else begin
            phase <= next_phase;
        end
    end

    // prescale cycle counter
    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            scale_cnt <= '0;
        end else begin
            scale_cnt <= next_scale_cnt;
        end
    end

    // prescale register
    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            prescale_value <= PIT_SCALE_RST;
        end else begin
            prescale_value <= next_prescale_value;
        end
    end

    // period register, feeds the reload path and the readback
    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            reload_period <= PIT_PERIOD_RST;
        end else begin
            reload_period <= next_reload_period;
        end
    end

    // down counter
    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            down_count <= PIT_COUNT_RST;
        end else begin
            down_count <= next_down_count;
        end
    end

    // interrupt request, high for one cycle per reload tick
    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            timer_irq_o <= 1'b0;
        end else begin
            timer_irq_o <= next_timer_irq;
        end
    end

    // registered read data
    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            rdata_o <= PIT_RDATA_RST;
        end else begin
            rdata_o <= next_rdata;
        end
    end

endmodule

/* File: tb/pit_timer_asserts.sv */
`timescale 1ns/1ns
module pit_asserts import pit_pkg::*; (
    input wire logic                   mclk_i,
    input wire logic                   resetn_i,
    input wire pit_req_t               req_i,
    input wire logic [PIT_MODE_W-1:0]  mode_status_word_i,
    input wire logic [PIT_COUNT_W-1:0] rdata_o,
    input wire logic                   timer_irq_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);
    // enable, strobes and address decode
    wire logic        on  = mode_status_word_i[PIT_ENABLE_BIT];
    wire logic        w   = req_i.wr;
    wire logic        r   = req_i.rd && !req_i.wr;
    wire logic        ac  = req_i.addr == PIT_ADDR_COUNT;
    wire logic        asc = req_i.addr == PIT_ADDR_SCALE;
    wire logic        ap  = req_i.addr == PIT_ADDR_PERIOD;
    wire logic [15:0] d   = req_i.wdata;
    // readback, hold and interrupt relations
    property p_off; !on |=> !timer_irq_o; endproperty
    a_off: assert property (p_off) else $error("irq halted");
    property p_per; w&&ap ##1 r&&ap |=> rdata_o==$past(d,2); endproperty
    a_per: assert property (p_per) else $error("period");
    property p_cnt; w&&ac&&!on ##1 r&&ac&&!on |=>
        rdata_o==$past(d,2); endproperty
    a_cnt: assert property (p_cnt) else $error("count");
    property p_scl; w&&asc ##1 r&&asc |=>
        rdata_o==($past(d,2)&16'h00ff); endproperty
    a_scl: assert property (p_scl) else $error("scale");
    property p_held; r&&ac&&!on ##1 r&&ac&&!on |=>
        $stable(rdata_o); endproperty
    a_held: assert property (p_held) else $error("held");
    property p_hi; r&&asc |=> rdata_o[15:8]==8'h00; endproperty
    a_hi: assert property (p_hi) else $error("width");
    property p_map; r&&req_i.addr>PIT_ADDR_COUNT |=>
        rdata_o==16'h0; endproperty
    a_map: assert property (p_map) else $error("unmapped");
    property p_nirq; w&&ac |=> !timer_irq_o; endproperty
    a_nirq: assert property (p_nirq) else $error("irq on write");
    // scenarios reached
    c_irq: cover property (timer_irq_o);
    c_on: cover property ($rose(on));
    c_map: cover property (r&&req_i.addr>PIT_ADDR_COUNT);
endmodule
bind pit_timer pit_asserts i_chk (.mclk_i, .resetn_i, .req_i,
    .mode_status_word_i, .rdata_o, .timer_irq_o);

/* File: tb/test_pit_timer.sv */
`timescale 1ns/1ns
module test_pit_timer import pit_pkg::*; ;
    logic        mclk = 0, resetn = 0, irq;
    logic [15:0] rdata;
    logic [6:0]  mode = '0;
    pit_req_t    req = '0;
    int          errors = 0, checks = 0, cyc = 0, last;
    pit_timer i_dut (.mclk_i(mclk), .resetn_i(resetn), .req_i(req),
        .mode_status_word_i(mode), .rdata_o(rdata), .timer_irq_o(irq));
    // clock, cycle count and hang ceiling
    initial forever #2 mclk = ~mclk;
    always @(posedge mclk) cyc <= cyc + 1;
    always @(negedge mclk) if (cyc > 900) give_verdict(1);
    // compare and tally
    task automatic chk(logic [15:0] got, exp);
        checks++;
        if (got !== exp) errors++;
        if (got !== exp) $display("Error %0t %h %h", $time, got, exp);
    endtask
    // one access from a falling edge; reads compare next cycle
    task automatic acc(logic wr, logic [3:0] a, logic [15:0] dat);
        req = '{wr, !wr, a, dat};
        @(negedge mclk);
        if (!wr) chk(rdata, dat);
    endtask
    // wait for an interrupt, check cycles since the last one
    task automatic wirq(int gap);
        req = '0;
        repeat (99) if (irq !== 1'b1) @(negedge mclk);
        chk(16'(cyc - last), 16'(gap));
        last = cyc;
        @(negedge mclk);
    endtask
    // tally and end the run
    task automatic give_verdict(int bump);
        errors += bump;
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // reset, register traffic, then timed interrupts
    initial begin
        repeat (8) @(negedge mclk);
        resetn = 1;
        for (int i = 0; i < 3; i++) acc(0, 4'(i), 16'h0000);
        acc(1, PIT_ADDR_PERIOD, 16'h0005);
        acc(0, PIT_ADDR_PERIOD, 16'h0005);
        acc(1, PIT_ADDR_SCALE, 16'hff01);
        acc(0, PIT_ADDR_SCALE, 16'h0001);
        acc(1, PIT_ADDR_COUNT, 16'h0005);
        acc(0, PIT_ADDR_COUNT, 16'h0005);
        acc(0, PIT_ADDR_COUNT, 16'h0005);
        acc(0, 4'h9, 16'h0000);
        mode[PIT_ENABLE_BIT] = 1'b1;
        last = cyc;
        wirq(13);
        acc(1, PIT_ADDR_PERIOD, 16'h0002);
        wirq(12);
        wirq(6);
        mode = '0;
        acc(1, PIT_ADDR_COUNT, 16'h0003);
        acc(0, PIT_ADDR_COUNT, 16'h0003);
        give_verdict(0);
    end
endmodule
